// *** rtl/table_unit_pkg.sv ***
// constants shared by the table read/write unit
package table_unit_pkg;
  localparam int ptr_w = 21;
  localparam int data_w = 8;
  localparam int instr_w = 16;
  localparam int hold_n = 8;
  localparam int hold_sel_w = 3;
  // opcode prefixes, upper 14 bits of the instruction word
  localparam logic [13:0] read_prefix = 14'h0002;
  localparam logic [13:0] write_prefix = 14'h0003;
  localparam int prefix_lsb = 2;
  localparam logic [1:0] mode_none = 2'h0;
  localparam logic [1:0] mode_post_inc = 2'h1;
  localparam logic [1:0] mode_post_dec = 2'h2;
  localparam logic [1:0] mode_pre_inc = 2'h3;
  localparam logic [20:0] ptr_reset = 21'h000000;
  localparam logic [7:0] latch_reset = 8'h00;
  localparam logic [7:0] hold_reset = 8'hff;
  localparam logic [20:0] ptr_one = 21'h000001;
endpackage : table_unit_pkg

// *** rtl/table_read_write_unit.sv ***
// table read/write unit: pointer, latch, holding registers
`timescale 1ns/1ps
module table_read_write_unit
  import table_unit_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // decoder side
  input wire logic instr_valid,
  input wire logic [15:0] instr_word,
  // program memory read port, word = {high byte, low byte}
  output logic [19:0] pm_word_addr,
  output logic pm_byte_sel,
  output logic pm_read,
  input wire logic [15:0] pm_read_word,
  // state seen by the core
  output logic [20:0] table_pointer,
  output logic [7:0] table_latch,
  output logic busy,
  output logic done,
  // holding registers toward the flash programming logic
  output logic [63:0] hold_bytes
);

  typedef enum logic [1:0] {idle, rd_second, wr_second} state_e;
  state_e state;

  logic [1:0] mode;
  logic [20:0] addr_ptr;
  // pre-incremented pointer, named so the read port can slice it
  logic [20:0] pre_ptr;
  logic [7:0] hold_mem [hold_n];

  function automatic logic [20:0] step_ptr(input logic [20:0] p, input logic [1:0] m);
    unique case (m)
      mode_post_inc, mode_pre_inc: step_ptr = p + ptr_one;
      mode_post_dec: step_ptr = p - ptr_one;
      mode_none: step_ptr = p;
    endcase
  endfunction : step_ptr

  logic is_read;
  logic is_write;
  assign is_read = instr_valid && state == idle
                   && instr_word[15:prefix_lsb] == read_prefix;
  assign is_write = instr_valid && state == idle
                    && instr_word[15:prefix_lsb] == write_prefix;

  // sequencing: first cycle decodes, second cycle does the access
  always_ff @(posedge core_clk) begin
    if (rst) begin
      state <= idle;
      mode <= mode_none;
      busy <= 1'b0;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      unique case (state)
        idle: begin
          if (is_read) begin
            state <= rd_second;
            mode <= instr_word[1:0];
            busy <= 1'b1;
          end else if (is_write) begin
            state <= wr_second;
            mode <= instr_word[1:0];
            busy <= 1'b1;
          end
        end
        rd_second, wr_second: begin
          state <= idle;
          busy <= 1'b0;
          done <= 1'b1;
        end
      endcase
    end
  end

  assign pre_ptr = step_ptr(table_pointer, mode_pre_inc);

  // address used by the access: pre-increment applies its step first
  assign addr_ptr = (mode == mode_pre_inc) ? step_ptr(table_pointer, mode)
                                           : table_pointer;

  // memory address driven during the second cycle
  always_ff @(posedge core_clk) begin
    if (rst) begin
      pm_word_addr <= '0;
      pm_byte_sel <= 1'b0;
      pm_read <= 1'b0;
    end else begin
      pm_read <= is_read;
      if (is_read) begin
        if (instr_word[1:0] == mode_pre_inc) begin
          pm_word_addr <= pre_ptr[20:1];
          pm_byte_sel <= pre_ptr[0];
        end else begin
          pm_word_addr <= table_pointer[20:1];
          pm_byte_sel <= table_pointer[0];
        end
      end
    end
  end

  // pointer update at the end of the instruction
  always_ff @(posedge core_clk) begin
    if (rst) begin
      table_pointer <= ptr_reset;
    end else if (state != idle) begin
      table_pointer <= step_ptr(table_pointer, mode);
    end
  end

  // latch written at the end of the second read cycle
  always_ff @(posedge core_clk) begin
    if (rst) begin
      table_latch <= latch_reset;
    end else if (state == rd_second) begin
      table_latch <= pm_byte_sel ? pm_read_word[15:8] : pm_read_word[7:0];
    end
  end

  // holding registers; program memory has no write path here
  always_ff @(posedge core_clk) begin
    if (rst) begin
      for (int i = 0; i < hold_n; i++) begin
        hold_mem[i] <= hold_reset;
      end
    end else if (state == wr_second) begin
      hold_mem[addr_ptr[hold_sel_w-1:0]] <= table_latch;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      hold_bytes <= {hold_n{hold_reset}};
    end else begin
      for (int i = 0; i < hold_n; i++) begin
        if (state == wr_second && addr_ptr[hold_sel_w-1:0] == hold_sel_w'(i)) begin
          hold_bytes[i*data_w +: data_w] <= table_latch;
        end else begin
          hold_bytes[i*data_w +: data_w] <= hold_mem[i];
        end
      end
    end
  end

  // helper: consecutive busy cycles; a stuck sequencer shows up here
  localparam int max_busy = 1;
  logic [1:0] busy_run;
  always_ff @(posedge core_clk) begin
    if (rst) begin
      busy_run <= 2'h0;
    end else if (busy) begin
      busy_run <= (busy_run == 2'h3) ? busy_run : busy_run + 2'h1;
    end else begin
      busy_run <= 2'h0;
    end
  end

  // checks: sequencing and timing
  a_read_two_cycles: assert property (
    @(posedge core_clk) disable iff (rst)
    is_read |=> pm_read && busy ##1 done && !busy)
    else $error("read did not finish in two cycles");
  a_write_two_cycles: assert property (
    @(posedge core_clk) disable iff (rst)
    is_write |=> busy && !pm_read ##1 done && !busy)
    else $error("write did not finish in two cycles");
  a_busy_run: assert property (
    @(posedge core_clk) disable iff (rst)
    busy_run <= max_busy)
    else $error("busy held too long");
  a_done_pulse: assert property (
    @(posedge core_clk) disable iff (rst)
    done |=> !done)
    else $error("done longer than one cycle");
  a_done_after_busy: assert property (
    @(posedge core_clk) disable iff (rst)
    done |-> $past(busy))
    else $error("done without busy cycle");
  a_busy_cause: assert property (
    @(posedge core_clk) disable iff (rst)
    $rose(busy) |-> $past(is_read || is_write))
    else $error("busy without accepted instruction");
  a_ignore_other: assert property (
    @(posedge core_clk) disable iff (rst)
    instr_valid && state == idle && !is_read && !is_write |=> !busy)
    else $error("foreign opcode accepted");
  a_mode_capture: assert property (
    @(posedge core_clk) disable iff (rst)
    (is_read || is_write) |=> mode == $past(instr_word[1:0]))
    else $error("mode field not captured");
  a_pm_read_state: assert property (
    @(posedge core_clk) disable iff (rst)
    pm_read |-> state == rd_second)
    else $error("memory read outside second cycle");
  a_pm_read_cause: assert property (
    @(posedge core_clk) disable iff (rst)
    pm_read |-> $past(is_read))
    else $error("memory read without table read");
  a_no_pm_on_write: assert property (
    @(posedge core_clk) disable iff (rst)
    is_write |=> !pm_read)
    else $error("write touched program memory");

  // checks: pointer behaviour
  a_none_keeps_ptr: assert property (
    @(posedge core_clk) disable iff (rst)
    (is_read || is_write) && instr_word[1:0] == mode_none |=> ##1 $stable(table_pointer))
    else $error("mode 0 changed pointer");
  a_idle_ptr: assert property (
    @(posedge core_clk) disable iff (rst)
    state == idle |=> $stable(table_pointer))
    else $error("pointer moved while idle");
  a_post_inc_ptr: assert property (
    @(posedge core_clk) disable iff (rst)
    is_read && instr_word[1:0] == mode_post_inc |=> pm_word_addr == table_pointer[20:1]
    ##1 table_pointer == $past(table_pointer) + ptr_one)
    else $error("post-increment wrong");
  a_post_dec_ptr: assert property (
    @(posedge core_clk) disable iff (rst)
    (is_read || is_write) && instr_word[1:0] == mode_post_dec
    |=> ##1 table_pointer == $past(table_pointer) - ptr_one)
    else $error("post-decrement wrong");
  a_pre_inc_addr: assert property (
    @(posedge core_clk) disable iff (rst)
    is_read && instr_word[1:0] == mode_pre_inc
    |=> {pm_word_addr, pm_byte_sel} == table_pointer + ptr_one)
    else $error("pre-increment address wrong");
  a_pre_inc_ptr: assert property (
    @(posedge core_clk) disable iff (rst)
    is_read && instr_word[1:0] == mode_pre_inc
    |=> ##1 table_pointer == $past(table_pointer) + ptr_one)
    else $error("pre-increment pointer wrong");
  a_read_addr: assert property (
    @(posedge core_clk) disable iff (rst)
    is_read && instr_word[1:0] != mode_pre_inc
    |=> {pm_word_addr, pm_byte_sel} == table_pointer)
    else $error("read address not the pointer");
  a_ptr_wrap: assert property (
    @(posedge core_clk) disable iff (rst)
    (is_read || is_write) && instr_word[1:0] == mode_post_dec && table_pointer == ptr_reset
    |=> ##1 table_pointer == ~ptr_reset)
    else $error("pointer did not wrap over 21 bits");
  a_wr_post_inc: assert property (
    @(posedge core_clk) disable iff (rst)
    is_write && instr_word[1:0] == mode_post_inc
    |=> ##1 table_pointer == $past(table_pointer) + ptr_one)
    else $error("write post-increment wrong");
  a_wr_pre_inc: assert property (
    @(posedge core_clk) disable iff (rst)
    is_write && instr_word[1:0] == mode_pre_inc
    |=> ##1 table_pointer == $past(table_pointer) + ptr_one)
    else $error("write pre-increment wrong");
  a_wr_pre_select: assert property (
    @(posedge core_clk) disable iff (rst)
    is_write && instr_word[1:0] == mode_pre_inc |=> addr_ptr == table_pointer + ptr_one)
    else $error("write pre-increment select wrong");
  a_wr_post_select: assert property (
    @(posedge core_clk) disable iff (rst)
    is_write && instr_word[1:0] != mode_pre_inc |=> addr_ptr == table_pointer)
    else $error("write select not the pointer");

  // checks: latch and holding registers
  a_latch_byte: assert property (
    @(posedge core_clk) disable iff (rst)
    state == rd_second |=> table_latch == (pm_byte_sel ? $past(pm_read_word[15:8])
                                                      : $past(pm_read_word[7:0])))
    else $error("latch took wrong byte");
  a_read_lsb_byte: assert property (
    @(posedge core_clk) disable iff (rst)
    state == rd_second && !pm_byte_sel |=> table_latch == $past(pm_read_word[7:0]))
    else $error("low byte not latched");
  a_read_msb_byte: assert property (
    @(posedge core_clk) disable iff (rst)
    state == rd_second && pm_byte_sel |=> table_latch == $past(pm_read_word[15:8]))
    else $error("high byte not latched");
  a_latch_only_read: assert property (
    @(posedge core_clk) disable iff (rst)
    state != rd_second |=> $stable(table_latch))
    else $error("latch changed outside read");
  a_hold_mem_write: assert property (
    @(posedge core_clk) disable iff (rst)
    state == wr_second |=> hold_mem[$past(addr_ptr[hold_sel_w-1:0])] == $past(table_latch))
    else $error("holding store not written");
  a_hold_select: assert property (
    @(posedge core_clk) disable iff (rst)
    state == wr_second |=> ##1 hold_bytes[$past(addr_ptr[hold_sel_w-1:0], 2) * data_w +: data_w]
    == $past(table_latch, 2))
    else $error("holding register not written");
  a_idle_hold: assert property (
    @(posedge core_clk) disable iff (rst)
    state == idle |=> $stable(hold_bytes))
    else $error("holding registers changed while idle");

endmodule : table_read_write_unit

// *** sim/pm_model.sv ***
// program memory model behind the unit's read port
`timescale 1ns/1ps
module pm_model (
  // read port
  input wire logic [19:0] pm_word_addr,
  input wire logic pm_read,
  output logic [15:0] pm_read_word
);
  logic [15:0] w;
  // high byte in [15:8], low byte in [7:0]
  assign w = {pm_word_addr[7:0] ^ 8'ha5,
              pm_word_addr[15:8] ^ pm_word_addr[7:0] ^ {4'h0, pm_word_addr[19:16]}};
  // inverse outside a read, so stale data cannot pass
  assign pm_read_word = pm_read ? w : ~w;
endmodule : pm_model

// *** sim/tb.sv ***
// self-checking bench for the table read/write unit
`timescale 1ns/1ps
module tb;
  import table_unit_pkg::*;
  logic core_clk = 0;
  logic rst = 1;
  logic instr_valid = 0;
  logic [15:0] instr_word = 16'h0000;
  logic [19:0] pm_word_addr;
  logic pm_byte_sel, pm_read, busy, done;
  logic [15:0] pm_read_word;
  logic [20:0] table_pointer;
  logic [7:0] table_latch;
  logic [63:0] hold_bytes;
  logic [63:0] hold = {8{8'hff}};
  logic [2:0] r;
  int err_total = 0, n_tests = 0, cycles = 0, ptr = 0, lat = 0, k;
  int seed = 32'hc0d58441;

  table_read_write_unit dut (.core_clk(core_clk), .rst(rst), .instr_valid(instr_valid),
    .instr_word(instr_word), .pm_word_addr(pm_word_addr), .pm_byte_sel(pm_byte_sel),
    .pm_read(pm_read), .pm_read_word(pm_read_word), .table_pointer(table_pointer),
    .table_latch(table_latch), .busy(busy), .done(done), .hold_bytes(hold_bytes));
  pm_model pm (.pm_word_addr(pm_word_addr), .pm_read(pm_read), .pm_read_word(pm_read_word));

  always #12.5 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 20000) begin
      err_total++;
      $display("CHECK FAILED %0t timeout", $time);
      test_done();
    end
  end

  function automatic int mem(input int a);
    logic [19:0] w;
    w = a[20:1];
    return a[0] ? (w[7:0] ^ 8'ha5) : (w[15:8] ^ w[7:0] ^ {4'h0, w[19:16]});
  endfunction : mem
  task automatic fail(input string m);
    err_total++;
    $display("CHECK FAILED %0t %s", $time, m);
  endtask : fail
  task automatic chk_ptr(input logic [20:0] got, input int exp);
    n_tests++;
    if (got !== exp[20:0]) fail("pointer or address");
  endtask : chk_ptr
  task automatic chk_byte(input logic [7:0] got, input int exp);
    n_tests++;
    if (got !== exp[7:0]) fail("latch or latency");
  endtask : chk_byte
  task automatic chk_hold(input logic [63:0] got, input logic [63:0] exp);
    n_tests++;
    if (got !== exp) fail("holding registers");
  endtask : chk_hold

  task automatic op(input logic wr, input logic [1:0] md);
    int a, i;
    @(posedge core_clk);
    instr_valid <= 1;
    instr_word <= {12'h000, 1'b1, wr, md};
    @(posedge core_clk);
    instr_valid <= 0;
    instr_word <= 16'($random(seed));
    if (md == mode_pre_inc) ptr = (ptr + 1) & 32'h1fffff;
    a = ptr;
    if (md == mode_post_inc) ptr = (ptr + 1) & 32'h1fffff;
    if (md == mode_post_dec) ptr = (ptr - 1) & 32'h1fffff;
    // read strobe stands only in the second cycle, address from then on
    #1;
    chk_byte({7'h00, pm_read}, wr ? 0 : 1);
    if (!wr) chk_ptr({pm_word_addr, pm_byte_sel}, a);
    i = 0;
    do begin
      @(posedge core_clk);
      #1;
      i++;
    end while (done !== 1'b1 && i < 8);
    chk_byte(i[7:0], 1);
    if (!wr) lat = mem(a);
    chk_ptr(table_pointer, ptr);
    chk_byte(table_latch, lat);
    if (wr) hold[(a % 8) * 8 +: 8] = lat[7:0];
    @(posedge core_clk);
    #1;
    chk_hold(hold_bytes, hold);
  endtask : op

  task automatic test_done;
    $display("comparisons %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : test_done

  initial begin
    repeat (12) @(posedge core_clk);
    rst <= 0;
    @(posedge core_clk);
    #1;
    chk_ptr(table_pointer, 0);
    chk_hold(hold_bytes, hold);
    for (k = 0; k < 3; k++) begin
      @(posedge core_clk);
      // other opcodes must be ignored
      instr_valid <= 1;
      instr_word <= 16'h0010 | 16'($random(seed));
      repeat (3) @(posedge core_clk);
      instr_valid <= 0;
      #1;
      chk_ptr(table_pointer, ptr);
    end
    for (k = 0; k < 400; k++) begin
      r = 3'($random(seed));
      op(r[2], r[1:0]);
    end
    test_done();
  end
endmodule : tb
